//--- rtl/ltcnt_top.v
// What this block does
// - counts in normal, stop and sleep modes
// - counts up one per slow tick
// - overflow in low power raises wake flag
// - enable bit written only with mask
// - irq enable written only with mask
// - enable one counts, zero holds value
// - first period after enable may shorten
// - irq on overflow only when enabled
// - overflow flag sticky until software clears
// - write one clears flag, zero keeps
// - two 16-bit words, 16-bit access only
// - reading one word freezes until other read
// - decode at blocking and non-blocking bases
`timescale 1ns/10ps
`default_nettype none
`include "ltcnt_map.vh"

module ltcnt_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // always-on slow clock pin
  input  wire        always_on_slow_clock,
  // power mode: high in stop or sleep
  input  wire        low_power_mode,
  // register access port
  input  wire        reg_sel,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        reg_wide,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_err,
  // events
  output reg         overflow_irq,
  output reg         counter_wake_flag,
  input  wire        wake_flag_clear,
  output wire [31:0] count_value
);

  reg         count_enable_bit_ff;
  reg         overflow_irq_enable_ff;
  reg         overflow_flag_ff;
  reg         freeze_ff;
  reg         frozen_hi_ff;
  reg         en_tick_gate_ff;
  reg  [15:0] nxt_rdata;
  reg         nxt_err;

  wire        tick;
  wire        wrap;
  wire        in_blk;
  wire        in_nbk;
  wire [7:0]  off;
  wire        hit;
  wire        acc;
  wire        is_ctrl_wide;
  wire        is_ctrl_lo;
  wire        is_ctrl_hi;
  wire        is_status;
  wire        is_rsvd;
  wire        is_cnt_hi;
  wire        is_cnt_lo;
  wire        cnt_ok;
  wire [7:0]  mask_byte;
  wire [7:0]  ctrl_byte;
  wire        mask_wr;
  wire        advance;
  wire        rd_hi;
  wire        rd_lo;
  wire [15:0] base_blk;
  wire [15:0] base_nbk;

  assign base_blk = `LTCNT_BASE_BLOCKING;
  assign base_nbk = `LTCNT_BASE_NONBLOCKING;
  assign in_blk   = (reg_addr[15:8] == base_blk[15:8]);
  assign in_nbk   = (reg_addr[15:8] == base_nbk[15:8]);
  assign off    = reg_addr[7:0];
  assign hit    = reg_sel && (in_blk || in_nbk);
  assign acc    = hit && (reg_wr || reg_rd);

  assign is_ctrl_wide = (off == `LTCNT_OFF_CTRL_MASK) && reg_wide;
  assign is_ctrl_hi   = (off == `LTCNT_OFF_CTRL_MASK) && !reg_wide;
  assign is_ctrl_lo   = (off == `LTCNT_OFF_CTRL);
  assign is_status    = (off == `LTCNT_OFF_STATUS) && !reg_wide;
  assign is_rsvd      = (off == `LTCNT_OFF_RSVD);
  assign is_cnt_hi    = (off == `LTCNT_OFF_CNT_UPPER);
  assign is_cnt_lo    = (off == `LTCNT_OFF_CNT_LOWER);
  assign cnt_ok       = reg_wide && (is_cnt_hi || is_cnt_lo);

  // a 16-bit write at the mask offset carries mask in the upper byte
  assign mask_byte = is_ctrl_wide ? reg_wdata[15:8] : reg_wdata[7:0];
  assign ctrl_byte = reg_wdata[7:0];
  assign mask_wr   = acc && reg_wr && (is_ctrl_wide || is_ctrl_hi);

  assign rd_hi = acc && reg_rd && cnt_ok && is_cnt_hi;
  assign rd_lo = acc && reg_rd && cnt_ok && is_cnt_lo;

  // no mode input gates the counting path
  ltcnt_tick_sync u_sync (
    .clk                  (clk),
    .rst_n                (rst_n),
    .always_on_slow_clock (always_on_slow_clock),
    .tick                 (tick)
  );

  // advance only when enabled and not frozen
  // a count read also blocks the tick of its own cycle, else a carry could split the halves
  assign advance = tick && count_enable_bit_ff && en_tick_gate_ff && !freeze_ff && !rd_hi && !rd_lo;

  ltcnt_counter #(
    .WIDTH (32)
  ) u_cnt (
    .clk         (clk),
    .rst_n       (rst_n),
    .advance     (advance),
    .load_hi     (acc && reg_wr && cnt_ok && is_cnt_hi),
    .load_lo     (acc && reg_wr && cnt_ok && is_cnt_lo),
    .load_data   (reg_wdata),
    .count_value (count_value),
    .wrap        (wrap)
  );

  // control bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_enable_bit_ff    <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
      en_tick_gate_ff        <= 1'b0;
    end else begin
      if (mask_wr && mask_byte[`LTCNT_BIT_EN_MASK]) begin
        count_enable_bit_ff <= ctrl_byte[`LTCNT_BIT_EN];
      end
      if (mask_wr && mask_byte[`LTCNT_BIT_IE_MASK]) begin
        overflow_irq_enable_ff <= ctrl_byte[`LTCNT_BIT_IE];
      end
      // first tick after enable may come early, up to one slow period short
      en_tick_gate_ff <= count_enable_bit_ff;
    end
  end

  // freeze between the two halves of a count read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_ff    <= 1'b0;
      frozen_hi_ff <= 1'b0;
    end else if (rd_hi || rd_lo) begin
      if (freeze_ff && (frozen_hi_ff != rd_hi)) begin
        freeze_ff <= 1'b0;
      end else begin
        freeze_ff    <= 1'b1;
        frozen_hi_ff <= rd_hi;
      end
    end
  end

  // sticky flag, set wins over clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_ff <= 1'b0;
    end else if (wrap) begin
      overflow_flag_ff <= 1'b1;
    end else if (acc && reg_wr && is_status && reg_wdata[`LTCNT_BIT_OVF]) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  // event outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_irq      <= 1'b0;
      counter_wake_flag <= 1'b0;
    end else begin
      // irq level tracks flag and enable
      overflow_irq <= (overflow_flag_ff || wrap) && overflow_irq_enable_ff;
      // wake flag set on low power overflow
      if (wrap && low_power_mode) begin
        counter_wake_flag <= 1'b1;
      end else if (wake_flag_clear) begin
        counter_wake_flag <= 1'b0;
      end
    end
  end

  always @* begin
    nxt_rdata = 16'h0000;
    nxt_err   = 1'b0;
    if (!acc) begin
      nxt_err = 1'b0;
    end else if (is_ctrl_wide) begin
      nxt_rdata = {8'h00, overflow_irq_enable_ff, 6'h00, count_enable_bit_ff};
    end else if (is_ctrl_hi) begin
      nxt_rdata = 16'h0000;
    end else if (is_ctrl_lo) begin
      nxt_rdata = {8'h00, overflow_irq_enable_ff, 6'h00, count_enable_bit_ff};
    end else if (is_status) begin
      nxt_rdata = {8'h00, overflow_flag_ff, 7'h00};
    end else if (is_rsvd) begin
      nxt_rdata = 16'h0000;
    end else if (cnt_ok && is_cnt_hi) begin
      nxt_rdata = count_value[31:16];
    end else if (cnt_ok && is_cnt_lo) begin
      nxt_rdata = count_value[15:0];
    end else begin
      nxt_err = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_err   <= 1'b0;
    end else begin
      reg_err <= nxt_err;
      if (acc && reg_rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

endmodule // ltcnt_top

`default_nettype wire

//--- rtl/ltcnt_map.vh
`ifndef LTCNT_MAP_VH
`define LTCNT_MAP_VH

// window bases in the global address space
`define LTCNT_BASE_BLOCKING     16'h0200
`define LTCNT_BASE_NONBLOCKING  16'h0300

// register offsets within the window
`define LTCNT_OFF_CTRL_MASK     8'h38
`define LTCNT_OFF_CTRL          8'h39
`define LTCNT_OFF_STATUS        8'h3a
`define LTCNT_OFF_RSVD          8'h3b
`define LTCNT_OFF_CNT_UPPER     8'h3c
`define LTCNT_OFF_CNT_LOWER     8'h3e

// field positions
`define LTCNT_BIT_EN            0
`define LTCNT_BIT_IE            7
`define LTCNT_BIT_EN_MASK       0
`define LTCNT_BIT_IE_MASK       7
`define LTCNT_BIT_OVF           7

// reset values
`define LTCNT_RST_CTRL          8'h00
`define LTCNT_RST_STATUS        8'h00
`define LTCNT_RST_COUNT         32'h0000_0000

// synchroniser depth for the slow clock pin
`define LTCNT_SYNC_STAGES       3

`endif

//--- rtl/ltcnt_tick_sync.v
`timescale 1ns/10ps
`default_nettype none

module ltcnt_tick_sync (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // slow clock from the always-on domain
  input  wire always_on_slow_clock,
  // one-cycle pulse per slow clock rising edge
  output wire tick
);

  reg  s1_ff;
  reg  s2_ff;
  reg  s3_ff;
  reg  lvl_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff <= always_on_slow_clock;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // level only changes once two settled stages agree
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign tick = (s2_ff == s3_ff) && s3_ff && !lvl_ff;

endmodule // ltcnt_tick_sync

`default_nettype wire

//--- rtl/ltcnt_counter.v
`timescale 1ns/10ps
`default_nettype none
`include "ltcnt_map.vh"

module ltcnt_counter #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // control
  input  wire             advance,
  input  wire             load_hi,
  input  wire             load_lo,
  input  wire [15:0]      load_data,
  // state
  output reg  [WIDTH-1:0] count_value,
  output wire             wrap
);

  reg [WIDTH-1:0] nxt_count;

  assign wrap = advance && (&count_value);

  always @* begin
    nxt_count = count_value;
    if (load_hi) begin
      nxt_count[WIDTH-1:16] = load_data;
    end else if (load_lo) begin
      nxt_count[15:0] = load_data;
    end else if (advance) begin
      nxt_count = count_value + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= `LTCNT_RST_COUNT;
    end else begin
      count_value <= nxt_count;
    end
  end

endmodule // ltcnt_counter

`default_nettype wire

//--- dv/ltcnt_props.sv
`timescale 1ns/10ps
`default_nettype none
module ltcnt_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_wide,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_err,
  // events
  input wire logic        low_power_mode,
  input wire logic        counter_wake_flag,
  input wire logic        wake_flag_clear,
  input wire logic [31:0] count_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       in_win;
  logic       rd_hi;
  logic       rd_lo;
  logic [1:0] half_ff;
  assign in_win = reg_sel && (reg_rd || reg_wr) && (reg_addr[15:8] == 8'h02 || reg_addr[15:8] == 8'h03);
  assign rd_hi = in_win && reg_rd && reg_wide && reg_addr[7:0] == 8'h3c;
  assign rd_lo = in_win && reg_rd && reg_wide && reg_addr[7:0] == 8'h3e;
  // tracks which half opened a coherent read, so only a first read is judged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      half_ff <= 2'h0;
    else if (rd_hi)
      half_ff <= (half_ff == 2'h2) ? 2'h0 : 2'h1;
    else if (rd_lo)
      half_ff <= (half_ff == 2'h1) ? 2'h0 : 2'h2;
  end
  sequence s_first_read;
    (rd_hi || rd_lo) && half_ff == 2'h0;
  endsequence
  sequence s_idle8;
    !reg_sel [*8];
  endsequence
  a_count_step: assert property (!$past(reg_sel && reg_wr) && !$past(reg_sel && reg_wr, 2)
    |-> count_value == $past(count_value) || count_value == $past(count_value) + 32'h1)
    else $error("count moved by other than one");
  a_read_freeze: assert property (s_first_read ##1 s_idle8 |-> count_value == $past(count_value, 6))
    else $error("count moved while half read");
  a_wake_cause: assert property ($rose(counter_wake_flag) |-> $past(low_power_mode) && count_value <= 32'h1)
    else $error("wake flag without low power wrap");
  a_wake_sticky: assert property ($fell(counter_wake_flag) |-> wake_flag_clear || $past(wake_flag_clear))
    else $error("wake flag dropped without clear");
  a_err_cause: assert property (reg_err |-> $past(reg_sel))
    else $error("error without access");
  a_byte_cnt_err: assert property (in_win && !reg_wide && reg_addr[7:1] == 7'h1e |=> reg_err)
    else $error("byte access to count not refused");
  a_outside_quiet: assert property (reg_sel && reg_addr[15:9] != 7'h01 |=> !reg_err)
    else $error("error outside window");
  a_mask_zero: assert property (in_win && reg_rd && !reg_wide && reg_addr[7:0] == 8'h38 |=> reg_rdata[7:0] == 8'h00)
    else $error("mask byte not zero");
endmodule // ltcnt_props
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        always_on_slow_clock = 1'b0;
  logic        low_power_mode = 1'b0;
  logic        reg_sel = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        reg_wide = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        wake_flag_clear = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_err;
  logic        overflow_irq;
  logic        counter_wake_flag;
  logic [31:0] count_value;
  logic [15:0] got;
  logic        err;
  logic [31:0] v;
  logic [31:0] c;
  int          error_cnt = 0;
  int          n_compared = 0;

  ltcnt_top DUT (.clk, .rst_n, .always_on_slow_clock, .low_power_mode, .reg_sel, .reg_wr, .reg_rd, .reg_wide,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_err, .overflow_irq, .counter_wake_flag, .wake_flag_clear, .count_value);

  always #5 clk = !clk;
  // odd half period puts only every fifth slow edge on the fast clock grid
  always #43 always_on_slow_clock = !always_on_slow_clock;

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    n_compared++;
    if (act !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask

  task automatic acc(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_sel = 1'b1;
    reg_wr = w;
    reg_rd = !w;
    reg_wide = wd;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    got = reg_rdata;
    err = reg_err;
    reg_sel = 1'b0;
  endtask

  task automatic wait_cnt(input logic [31:0] t);
    for (int i = 0; i < 400 && count_value !== t; i++) begin
      @(posedge clk);
      #1;
    end
    chk("count reached", t, count_value);
    if (count_value !== t)
      stop_test();
  endtask

  initial begin
    void'($urandom(32'h5b4b53d8));
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    acc(1'b0, 1'b0, 16'h023a, 16'h0000);
    chk("status reset", 32'h0, {24'h0, got[7:0]});
    acc(1'b0, 1'b0, 16'h0238, 16'h0000);
    chk("mask byte", 32'h0, {24'h0, got[7:0]});
    acc(1'b0, 1'b0, 16'h023b, 16'h0000);
    chk("reserved byte", 32'h0, {24'h0, got[7:0]});
    acc(1'b1, 1'b1, 16'h0238, 16'h0081);
    acc(1'b0, 1'b0, 16'h0239, 16'h0000);
    chk("ctrl no mask", 32'h0, {24'h0, got[7:0]});
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      acc(1'b1, 1'b1, k[0] ? 16'h033c : 16'h023c, v[31:16]);
      acc(1'b1, 1'b1, k[0] ? 16'h033e : 16'h023e, v[15:0]);
      acc(1'b0, 1'b1, k[0] ? 16'h033c : 16'h023c, 16'h0000);
      chk("upper word", {16'h0, v[31:16]}, {16'h0, got});
      acc(1'b0, 1'b1, k[0] ? 16'h033e : 16'h023e, 16'h0000);
      chk("lower word", {16'h0, v[15:0]}, {16'h0, got});
      chk("disabled hold", v, count_value);
    end
    acc(1'b1, 1'b0, 16'h023c, 16'h00ff);
    chk("byte refused", 32'h1, {31'h0, err});
    chk("byte no effect", v, count_value);
    acc(1'b0, 1'b0, 16'h0438, 16'h0000);
    chk("outside quiet", 32'h0, {31'h0, err});
    acc(1'b1, 1'b1, 16'h023c, 16'hffff);
    acc(1'b1, 1'b1, 16'h023e, 16'hfffe);
    acc(1'b1, 1'b1, 16'h0238, 16'h8181);
    low_power_mode = 1'b1;
    wait_cnt(32'h1);
    chk("irq on", 32'h1, {31'h0, overflow_irq});
    chk("wake set", 32'h1, {31'h0, counter_wake_flag});
    acc(1'b1, 1'b0, 16'h023a, 16'h0000);
    acc(1'b0, 1'b0, 16'h023a, 16'h0000);
    chk("flag kept", 32'h80, {24'h0, got[7:0]});
    acc(1'b1, 1'b0, 16'h023a, 16'h0080);
    acc(1'b0, 1'b0, 16'h023a, 16'h0000);
    chk("flag cleared", 32'h0, {24'h0, got[7:0]});
    chk("irq off", 32'h0, {31'h0, overflow_irq});
    wake_flag_clear = 1'b1;
    @(posedge clk);
    #1;
    wake_flag_clear = 1'b0;
    chk("wake cleared", 32'h0, {31'h0, counter_wake_flag});
    low_power_mode = 1'b0;
    acc(1'b0, 1'b1, 16'h033c, 16'h0000);
    c = count_value;
    chk("frozen upper", {16'h0, c[31:16]}, {16'h0, got});
    repeat (40) @(posedge clk);
    #1;
    chk("frozen", c, count_value);
    acc(1'b0, 1'b1, 16'h033e, 16'h0000);
    chk("frozen lower", {16'h0, c[15:0]}, {16'h0, got});
    repeat (40) @(posedge clk);
    #1;
    chk("resumed", 32'h1, {31'h0, count_value !== c});
    acc(1'b1, 1'b1, 16'h0238, 16'h8001);
    acc(1'b1, 1'b1, 16'h0238, 16'h0100);
    acc(1'b0, 1'b0, 16'h0239, 16'h0000);
    chk("ctrl masked", 32'h0, {24'h0, got[7:0]});
    acc(1'b1, 1'b1, 16'h023c, 16'hffff);
    acc(1'b1, 1'b1, 16'h023e, 16'hffff);
    acc(1'b1, 1'b1, 16'h0238, 16'h0101);
    wait_cnt(32'h1);
    acc(1'b0, 1'b0, 16'h023a, 16'h0000);
    chk("flag set", 32'h80, {24'h0, got[7:0]});
    chk("irq masked", 32'h0, {31'h0, overflow_irq});
    chk("no wake", 32'h0, {31'h0, counter_wake_flag});
    stop_test();
  end
endmodule // tb

bind ltcnt_top ltcnt_props u_props (.clk, .rst_n, .reg_sel, .reg_wr, .reg_rd, .reg_wide, .reg_addr, .reg_rdata,
  .reg_err, .low_power_mode, .counter_wake_flag, .wake_flag_clear, .count_value);
`default_nettype wire
